// ---- hdl/paging_sched_defs.svh ----
// timing constants and register map of the paging power-save scheduler
`ifndef PAGING_SCHED_DEFS_SVH
`define PAGING_SCHED_DEFS_SVH

// time base
`define CLK_PERIOD_NS 100
`define MS_NS 1000000
`define MS_CYCLES ((`MS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// gsm: frame time in microseconds and frames per multiframe
`define GSM_FRAME_US 4615
`define GSM_FRAMES 51
`define GSM_DRX_MIN 4'h2
`define GSM_DRX_MAX 4'h9
// lte: one cycle unit in ms
`define LTE_UNIT_MS 10
// edrx window unit in ms, paging cycle bounds in ms
`define PTW_UNIT_MS 2560
`define PCL_MIN_MS 5120
`define PCL_MAX_MS 10485760
// listening occasion length in ms
`define LISTEN_MS 10

// register byte offsets
`define REG_CTRL 8'h00
`define REG_DRX 8'h04
`define REG_EDRX 8'h08
`define REG_PSM 8'h0c
`define REG_STATUS 8'h10

// control bit positions
`define CTRL_RUN 0
`define CTRL_EDRX_EN 1
`define CTRL_SLEEP_EN 2
`define CTRL_SUSP_EN 3
`define CTRL_PSM_EN 4
`define CTRL_EDRX_OK 5
`define CTRL_T3324_OK 6
`define CTRL_RESET 32'h0000_0000

`endif

// ---- hdl/paging_sched_pkg.sv ----
// types of the paging power-save scheduler
package paging_sched_pkg;
  typedef enum logic [1:0] {
    RAT_GSM = 2'h0,
    RAT_CATM1 = 2'h1,
    RAT_NB = 2'h2
  } rat_e;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_LISTEN = 5'h02,
    ST_SLEEP = 5'h04,
    ST_PSM = 5'h08,
    ST_ESUSP = 5'h10
  } state_e;
endpackage : paging_sched_pkg

// ---- hdl/ms_tick.sv ----
// millisecond tick generator
`timescale 1ns/1ps
`include "paging_sched_defs.svh"
module ms_tick #(
  parameter int CYCLES = `MS_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  output logic tick
);
  logic [31:0] cnt_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 32'h0;
      tick <= 1'b0;
    end else if (cnt_q == 32'(CYCLES - 1)) begin
      cnt_q <= 32'h0;
      tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 32'h1;
      tick <= 1'b0;
    end
  end
endmodule : ms_tick

// ---- hdl/paging_power_save_scheduler.sv ----
// paging power-save scheduler with wishbone registers
// Operation
// R1: gsm interval is 4.615ms times 51 times drx
// R2: gsm drx accepted from 2 to 9
// R3: gsm keeps extended drx disabled
// R4: lte interval is drx cycle times 10ms
// R5: cat m1 cycles 32,64,128,256 supported
// R6: nb cycles 128,256,512,1024 supported
// R7: sleep between listening occasions
// R8: edrx listens only in paging window
// R9: edrx cycle from 5.12s to 10485.76s
// R10: window is (value plus one) times 2560ms
// R11: edrx suspend blocks regular psm suspend
// R12: psm after active timer expiry or zero
// R13: psm only: standard drx until timer expiry
// R14: edrx only: edrx cycles, optional suspend
// R15: paging monitored only while active timer runs
// R16: no psm while uplink pending
// R17: stay registered during psm
// R18: all durations from one millisecond timebase
`timescale 1ns/1ps
`include "paging_sched_defs.svh"
module paging_power_save_scheduler #(
  parameter int MS_CYCLES = `MS_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic uplinkPending,
  output logic listening,
  output logic sleeping,
  output logic psmActive,
  output logic edrxSuspend,
  output logic registered
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic [15:0] drx_q;
  logic [1:0] rat_q;
  logic [23:0] pcl_q;
  logic [3:0] ptw_q;
  logic [23:0] t3324_q;
  logic drxBad_q;
  logic pclBad_q;
  paging_sched_pkg::state_e state_q;
  logic [23:0] phase_q;
  logic [23:0] listen_q;
  logic [23:0] active_q;
  logic tick;
  logic wbReq;

  ms_tick #(.CYCLES(MS_CYCLES)) u_tick (
    .clock(clock),
    .rst_n(rst_n),
    .tick(tick)
  ); // [R18]

  assign wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // ----------------------------------------------------------------
  // interval arithmetic
  // ----------------------------------------------------------------
  logic [23:0] interval;
  logic [23:0] window;
  logic drxLegal;
  logic edrxOn;
  logic [31:0] gsmUs;
  always_comb begin
    gsmUs = 32'(`GSM_FRAME_US * `GSM_FRAMES) * {16'h0, drx_q}; // [R1]
    drxLegal = 1'b0;
    case (paging_sched_pkg::rat_e'(rat_q))
      paging_sched_pkg::RAT_GSM:
        drxLegal = drx_q >= 16'(`GSM_DRX_MIN) &&
          drx_q <= 16'(`GSM_DRX_MAX); // [R2]
      paging_sched_pkg::RAT_CATM1:
        drxLegal = drx_q == 16'h20 || drx_q == 16'h40 ||
          drx_q == 16'h80 || drx_q == 16'h100; // [R5]
      paging_sched_pkg::RAT_NB:
        drxLegal = drx_q == 16'h80 || drx_q == 16'h100 ||
          drx_q == 16'h200 || drx_q == 16'h400; // [R6]
      default: drxLegal = 1'b0;
    endcase
    if (rat_q == paging_sched_pkg::RAT_GSM) begin
      interval = 24'((gsmUs + 32'd999) / 32'd1000); // [R1]
    end else begin
      interval = 24'(drx_q) * 24'(`LTE_UNIT_MS); // [R4]
    end
    window = (24'(ptw_q) + 24'h1) * 24'(`PTW_UNIT_MS); // [R10]
    edrxOn = ctrl_q[`CTRL_EDRX_EN] && ctrl_q[`CTRL_EDRX_OK] &&
      rat_q != paging_sched_pkg::RAT_GSM && !pclBad_q; // [R3] [R14]
  end

  // ----------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wbReq;
      wb_dat_o <= 32'h0;
      if (wbReq && !wb_we_i) begin
        case (wb_adr_i)
          `REG_CTRL: wb_dat_o <= ctrl_q;
          `REG_DRX: wb_dat_o <= {14'h0, rat_q, drx_q};
          `REG_EDRX: wb_dat_o <= {ptw_q, 4'h0, pcl_q};
          `REG_PSM: wb_dat_o <= {8'h0, t3324_q};
          `REG_STATUS: wb_dat_o <= {19'h0, pclBad_q, drxBad_q,
            drxLegal, edrxOn, 4'h0, 5'(state_q)};
          default: wb_dat_o <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `CTRL_RESET;
      drx_q <= 16'h0;
      rat_q <= 2'h0;
      pcl_q <= 24'h0;
      ptw_q <= 4'h0;
      t3324_q <= 24'h0;
    end else if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i) begin
      case (wb_adr_i)
        `REG_CTRL: begin
          if (wb_sel_i[0]) ctrl_q[7:0] <= wb_dat_i[7:0];
        end
        `REG_DRX: begin
          if (wb_sel_i[0]) drx_q[7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1]) drx_q[15:8] <= wb_dat_i[15:8];
          if (wb_sel_i[2]) rat_q <= wb_dat_i[17:16];
        end
        `REG_EDRX: begin
          if (wb_sel_i[0]) pcl_q[7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1]) pcl_q[15:8] <= wb_dat_i[15:8];
          if (wb_sel_i[2]) pcl_q[23:16] <= wb_dat_i[23:16];
          if (wb_sel_i[3]) ptw_q <= wb_dat_i[31:28];
        end
        `REG_PSM: begin
          if (wb_sel_i[0]) t3324_q[7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1]) t3324_q[15:8] <= wb_dat_i[15:8];
          if (wb_sel_i[2]) t3324_q[23:16] <= wb_dat_i[23:16];
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      drxBad_q <= 1'b0;
      pclBad_q <= 1'b0;
    end else begin
      drxBad_q <= !drxLegal;
      pclBad_q <= pcl_q < 24'(`PCL_MIN_MS) ||
        pcl_q > 24'(`PCL_MAX_MS); // [R9]
    end
  end

  // ----------------------------------------------------------------
  // paging state machine
  // ----------------------------------------------------------------
  logic psmAllowed;
  logic activeRun;
  logic [23:0] cycleLen;
  logic [23:0] listenLen;
  always_comb begin
    activeRun = active_q != 24'h0; // [R15]
    psmAllowed = ctrl_q[`CTRL_PSM_EN] && ctrl_q[`CTRL_T3324_OK] &&
      !(edrxOn && ctrl_q[`CTRL_SUSP_EN]) &&
      !uplinkPending && !activeRun; // [R11] [R12] [R16]
    cycleLen = edrxOn ? pcl_q : interval; // [R8] [R13]
    listenLen = edrxOn ? window : 24'(`LISTEN_MS);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= paging_sched_pkg::ST_IDLE;
      phase_q <= 24'h0;
      listen_q <= 24'h0;
    end else begin
      case (state_q)
        paging_sched_pkg::ST_IDLE: begin
          if (ctrl_q[`CTRL_RUN] && drxLegal) begin
            state_q <= paging_sched_pkg::ST_LISTEN;
            phase_q <= 24'h0;
            listen_q <= listenLen;
          end
        end
        paging_sched_pkg::ST_LISTEN, paging_sched_pkg::ST_SLEEP,
        paging_sched_pkg::ST_ESUSP: begin
          if (!ctrl_q[`CTRL_RUN]) begin
            state_q <= paging_sched_pkg::ST_IDLE;
          end else if (psmAllowed) begin
            state_q <= paging_sched_pkg::ST_PSM; // [R12]
          end else if (tick) begin
            if (phase_q + 24'h1 >= cycleLen) begin
              phase_q <= 24'h0;
              state_q <= paging_sched_pkg::ST_LISTEN; // [R7]
            end else begin
              phase_q <= phase_q + 24'h1;
              if (phase_q + 24'h1 >= listen_q) begin
                state_q <= (edrxOn && ctrl_q[`CTRL_SUSP_EN] &&
                  ctrl_q[`CTRL_SLEEP_EN]) ?
                  paging_sched_pkg::ST_ESUSP :
                  paging_sched_pkg::ST_SLEEP; // [R7] [R11] [R14]
              end
            end
          end
          if (state_q == paging_sched_pkg::ST_LISTEN && tick &&
              phase_q == 24'h0) begin
            listen_q <= listenLen; // [R8] [R10]
          end
        end
        paging_sched_pkg::ST_PSM: begin
          if (!ctrl_q[`CTRL_RUN] || uplinkPending) begin
            state_q <= paging_sched_pkg::ST_IDLE;
          end
        end
        default: state_q <= paging_sched_pkg::ST_IDLE;
      endcase
    end
  end

  // active timer: reloaded on each run start, counts ms
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      active_q <= 24'h0;
    end else if (state_q == paging_sched_pkg::ST_IDLE) begin
      active_q <= ctrl_q[`CTRL_T3324_OK] ? t3324_q : 24'h0;
    end else if (tick && activeRun) begin
      active_q <= active_q - 24'h1; // [R15] [R18]
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      listening <= 1'b0;
      sleeping <= 1'b0;
      psmActive <= 1'b0;
      edrxSuspend <= 1'b0;
      registered <= 1'b0;
    end else begin
      listening <= state_q == paging_sched_pkg::ST_LISTEN &&
        (!ctrl_q[`CTRL_PSM_EN] || activeRun ||
        !ctrl_q[`CTRL_T3324_OK]); // [R15]
      sleeping <= state_q == paging_sched_pkg::ST_SLEEP; // [R7]
      psmActive <= state_q == paging_sched_pkg::ST_PSM;
      edrxSuspend <= state_q == paging_sched_pkg::ST_ESUSP; // [R14]
      registered <= state_q != paging_sched_pkg::ST_IDLE; // [R17]
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_noPsmUplink;
    @(posedge clock) disable iff (!rst_n)
      uplinkPending |=> state_q != paging_sched_pkg::ST_PSM;
  endproperty
  a_noPsmUplink: assert property (p_noPsmUplink) // [R16]
    else $error("psm entered with uplink pending");

  property p_gsmNoEdrx;
    @(posedge clock) disable iff (!rst_n)
      rat_q == paging_sched_pkg::RAT_GSM |-> !edrxOn;
  endproperty
  a_gsmNoEdrx: assert property (p_gsmNoEdrx) // [R3]
    else $error("edrx active on gsm");

  property p_suspBlocksPsm;
    @(posedge clock) disable iff (!rst_n)
      (edrxOn && ctrl_q[`CTRL_SUSP_EN]) |=>
        state_q != paging_sched_pkg::ST_PSM || $past(state_q) ==
        paging_sched_pkg::ST_PSM;
  endproperty
  a_suspBlocksPsm: assert property (p_suspBlocksPsm) // [R11]
    else $error("psm entered under edrx suspend");

  property p_psmAfterTimer;
    @(posedge clock) disable iff (!rst_n)
      $rose(psmActive) |-> $past(active_q, 2) == 24'h0;
  endproperty
  a_psmAfterTimer: assert property (p_psmAfterTimer) // [R12]
    else $error("psm before active timer expiry");

  property p_ltInterval;
    @(posedge clock) disable iff (!rst_n)
      (rat_q != paging_sched_pkg::RAT_GSM && !edrxOn && tick &&
        ctrl_q[`CTRL_RUN] && !psmAllowed &&
        state_q == paging_sched_pkg::ST_SLEEP &&
        phase_q + 24'h1 == 24'(drx_q) * 24'd10) |=>
        state_q == paging_sched_pkg::ST_LISTEN;
  endproperty
  a_ltInterval: assert property (p_ltInterval) // [R4]
    else $error("lte interval wrong");

  property p_window;
    @(posedge clock) disable iff (!rst_n)
      (state_q == paging_sched_pkg::ST_LISTEN && tick && edrxOn &&
        phase_q == 24'h0) |=>
        listen_q == (24'($past(ptw_q)) + 24'h1) * 24'd2560;
  endproperty
  a_window: assert property (p_window) // [R10]
    else $error("window length wrong");

  property p_gsmDrx;
    @(posedge clock) disable iff (!rst_n)
      (rat_q == paging_sched_pkg::RAT_GSM && drx_q >= 16'h2 &&
        drx_q <= 16'h9) |-> drxLegal;
  endproperty
  a_gsmDrx: assert property (p_gsmDrx) // [R2]
    else $error("legal gsm drx refused");

  sequence s_ack;
    ##1 wb_ack_o ##1 !wb_ack_o;
  endsequence
  property p_ackOnce;
    @(posedge clock) disable iff (!rst_n)
      (wbReq) |-> s_ack;
  endproperty
  a_ackOnce: assert property (p_ackOnce) // [R18]
    else $error("bus ack not single cycle");

  property p_registered;
    @(posedge clock) disable iff (!rst_n)
      psmActive |-> registered;
  endproperty
  a_registered: assert property (p_registered) // [R17]
    else $error("not registered in psm");
endmodule : paging_power_save_scheduler

// ---- bench/paging_network_model.sv ----
// network side model assigning paging drx values
`timescale 1ns/1ps
module paging_network_model (
  input wire paging_sched_pkg::rat_e rat,
  input wire logic [2:0] idx,
  output logic [15:0] drxValue
);
  // ----------------------------------------
  // assigned drx value by network kind
  // ----------------------------------------
  always_comb begin
    case (rat)
      paging_sched_pkg::RAT_GSM: drxValue = 16'h2 + {13'h0, idx};
      paging_sched_pkg::RAT_CATM1: drxValue = 16'h20 << idx[1:0];
      default: drxValue = 16'h80 << idx[1:0];
    endcase
  end
endmodule : paging_network_model

// ---- bench/paging_power_save_scheduler_tb.sv ----
// self-checking bench of the paging power-save scheduler
`timescale 1ns/1ps
`include "paging_sched_defs.svh"
`define CHECK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  failures++; $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module paging_power_save_scheduler_tb;
  // ----------------------------------------
  // signals and rows
  // ----------------------------------------
  logic clock, rst_n, cyc, stb, we, upl, ack;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, dato;
  logic listening, sleeping, psmActive, edrxSuspend, registered;
  logic [4:0] outs;
  paging_sched_pkg::rat_e rat;
  logic [2:0] idx;
  logic [15:0] drxValue;
  int failures = 0;
  int n_compared = 0;
  int cnt, n, m;
  typedef struct {paging_sched_pkg::rat_e r; logic [2:0] i; int ms;} row_s;
  row_s rows [4] = '{
    '{paging_sched_pkg::RAT_GSM, 3'h0, 471},
    '{paging_sched_pkg::RAT_GSM, 3'h1, 707},
    '{paging_sched_pkg::RAT_CATM1, 3'h0, 320},
    '{paging_sched_pkg::RAT_NB, 3'h0, 1280}};
  int pcl [4] = '{5119, 5120, 10485760, 10485761};

  paging_power_save_scheduler #(.MS_CYCLES(10)) paging_power_save_scheduler_i (
    .clock(clock), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
    .wb_dat_o(dato), .wb_ack_o(ack), .uplinkPending(upl),
    .listening(listening), .sleeping(sleeping), .psmActive(psmActive),
    .edrxSuspend(edrxSuspend), .registered(registered));
  paging_network_model paging_network_model_i (
    .rat(rat), .idx(idx), .drxValue(drxValue));
  assign outs = {listening, sleeping, psmActive, edrxSuspend, registered};

  initial begin
    clock = 0;
    forever #50 clock = ~clock;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic conclude;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude

  task automatic hang;
    failures++;
    conclude();
  endtask : hang

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    cnt = 0;
    do begin
      @(posedge clock);
      cnt++;
    end while (ack !== 1'b1 && cnt < 20);
    if (ack !== 1'b1) hang();
    rdat = dato;
    cyc <= 0;
    stb <= 0;
    we <= 0;
  endtask : wb

  function automatic logic pick(input int w);
    return (w == 0) ? listening : (w == 1) ? psmActive : edrxSuspend;
  endfunction : pick

  task automatic waitfor(input int w, input logic v, input int lim);
    cnt = 0;
    while (pick(w) !== v && cnt < lim) begin
      @(negedge clock);
      cnt++;
    end
    if (pick(w) !== v) hang();
  endtask : waitfor

  task automatic span(input logic v, output int k);
    k = 0;
    while (listening === v && k < 30000) begin
      @(negedge clock);
      k++;
    end
    if (k >= 30000) hang();
  endtask : span

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst_n = 0;
    cyc = 0;
    stb = 0;
    we = 0;
    adr = 0;
    wdat = 0;
    upl = 0;
    rat = paging_sched_pkg::RAT_GSM;
    idx = 0;
    repeat (12) @(negedge clock);
    `CHECK("outs", 5'h0, outs)
    @(posedge clock);
    rst_n <= 1;
    wb(0, `REG_STATUS, 0);
    `CHECK("state", paging_sched_pkg::ST_IDLE, rdat[4:0])
    wb(0, 8'h14, 0);
    `CHECK("unmapped", 32'h0, rdat)
    wb(1, `REG_CTRL, 32'h0000ff00);
    wb(0, `REG_CTRL, 0);
    `CHECK("ctrl", 32'h0, rdat)
    foreach (rows[k]) begin
      rat <= rows[k].r;
      idx <= rows[k].i;
      wb(1, `REG_CTRL, 32'h0);
      wb(1, `REG_DRX, {14'h0, rat, drxValue});
      wb(1, `REG_CTRL, 32'h5);
      waitfor(0, 1, 30000);
      waitfor(0, 0, 30000);
      waitfor(0, 1, 30000);
      span(1, n);
      `CHECK("sleeping", 1'b1, sleeping)
      span(0, m);
      `CHECK("listen", 100, n)
      `CHECK("period", rows[k].ms * 10, n + m)
    end
    wb(1, `REG_CTRL, 32'h0);
    wb(1, `REG_DRX, 32'h1);
    wb(0, `REG_STATUS, 0);
    `CHECK("drx low", 2'h2, rdat[11:10])
    wb(1, `REG_DRX, 32'h9);
    wb(1, `REG_CTRL, 32'h23);
    wb(0, `REG_STATUS, 0);
    `CHECK("drx high", 3'h2, rdat[11:9])
    wb(1, `REG_DRX, 32'h10020);
    foreach (pcl[k]) begin
      wb(1, `REG_EDRX, pcl[k]);
      wb(0, `REG_STATUS, 0);
      `CHECK("pcl", k % 3 ? 3'h3 : 3'h6, {rdat[12], rdat[10:9]})
    end
    wb(1, `REG_CTRL, 32'h0);
    wb(1, `REG_PSM, 32'h0);
    upl <= 1;
    wb(1, `REG_CTRL, 32'h55);
    repeat (500) @(negedge clock);
    `CHECK("psm upl", 1'b0, psmActive)
    @(posedge clock);
    upl <= 0;
    waitfor(1, 1, 300);
    `CHECK("registered", 1'b1, registered)
    `CHECK("no listen", 1'b0, listening)
    wb(1, `REG_CTRL, 32'h0);
    wb(1, `REG_PSM, 32'd20);
    wb(1, `REG_CTRL, 32'h55);
    repeat (150) @(negedge clock);
    `CHECK("psm early", 1'b0, psmActive)
    waitfor(1, 1, 300);
    `CHECK("psm late", 1'b1, psmActive)
    wb(1, `REG_CTRL, 32'h0);
    wb(1, `REG_EDRX, 32'h1400);
    wb(1, `REG_CTRL, 32'h7f);
    waitfor(2, 1, 26000);
    `CHECK("ptw", 1'b1, cnt > 25400)
    `CHECK("susp psm", 1'b0, psmActive)
    `CHECK("ptw over", 1'b0, listening)
    @(posedge clock);
    rst_n <= 0;
    repeat (2) @(posedge clock);
    `CHECK("outs rst", 5'h0, outs)
    rst_n <= 1;
    wb(0, `REG_EDRX, 0);
    `CHECK("edrx rst", 32'h0, rdat)
    conclude();
  end
endmodule : paging_power_save_scheduler_tb
